// ### clk_ctrl_pkg.sv
// package: register map, field layout and reset values of the clock control block
package clk_ctrl_pkg;
   localparam logic [2:0] REG_ADDR_W         = 3'h3;
   localparam logic [2:0] OFS_OSC_CONTROL    = 3'h0;
   localparam logic [2:0] OFS_CLOCK_DIVISOR  = 3'h1;
   localparam logic [2:0] OFS_PLL_FEEDBACK   = 3'h2;
   localparam logic [2:0] OFS_RC_TUNING      = 3'h3;
   localparam logic [2:0] OFS_UNLOCK         = 3'h4;
   localparam logic [15:0] UNLOCK_KEY1       = 16'h0046;
   localparam logic [15:0] UNLOCK_KEY2       = 16'h0057;
   // osc_control field positions
   localparam int CUR_LSB    = 12;
   localparam int NEW_LSB    = 8;
   localparam int FREEZE_BIT = 7;
   localparam int LOCK_BIT   = 5;
   localparam int FAIL_BIT   = 3;
   localparam int SEC_BIT    = 1;
   localparam int REQ_BIT    = 0;
   // clock_divisor field positions
   localparam int ROI_BIT    = 15;
   localparam int RED_LSB    = 12;
   localparam int REDEN_BIT  = 11;
   localparam int RCDIV_LSB  = 8;
   localparam int POST_LSB   = 6;
   localparam int PRE_LSB    = 0;
   // reset values
   localparam logic [2:0] RED_RESET   = 3'h3;
   localparam logic [2:0] RCDIV_RESET = 3'h0;
   localparam logic [1:0] POST_RESET  = 2'h1;
   localparam logic [4:0] PRE_RESET   = 5'h00;
   localparam logic [8:0] MULT_RESET  = 9'h030;
   localparam logic [5:0] TRIM_RESET  = 6'h00;
   // stable cycles of the new source before the switch
   localparam logic [3:0] SETTLE_CYCLES = 4'hA;

   typedef enum logic [2:0] {
      SRC_RC       = 3'b000,
      SRC_RC_PLL   = 3'b001,
      SRC_PRI      = 3'b010,
      SRC_PRI_PLL  = 3'b011,
      SRC_SEC      = 3'b100,
      SRC_LP_RC    = 3'b101,
      SRC_RC_DIV16 = 3'b110,
      SRC_RC_DIVN  = 3'b111
   } src_sel_t;

   typedef struct packed {
      logic [2:0] reduction_ratio;
      logic       reduction_active;
      logic [2:0] rc_postscaler;
      logic [1:0] pll_output_divider;
      logic [4:0] pll_input_prescaler;
      logic [8:0] pll_feedback_multiplier;
      logic [5:0] rc_trim;
   } clk_cfg_t;

   typedef struct packed {
      logic [2:0] addr;
      logic [15:0] wdata;
      logic       wr;
      logic       rd;
   } reg_req_t;
endpackage

// ### clk_ctrl.sv
// clock source select, switch sequencing and divider control registers
//
// Operation
// - current source field reads active clock with eight-way source encoding
// - new source field, same encoding, loaded from configuration at power-on
// - freeze bit with lock permit blocks new source, request, rc postscaler and pll setting writes
// - pll lock status reads one when the pll is locked, cleared at switch start
// - clock fail flag set by monitor, software may only clear it
// - secondary oscillator enable bit turns that oscillator on or off
// - software sets switch request, device clears it on completion
// - oscillator control writes accepted only after the unlock sequence
// - these registers reset only by power-on reset
// - recover on interrupt lets any interrupt clear clock reduction enable
// - reduction field selects divide 1 to 128, reset value divide by 8
// - reduction enable applies field, otherwise ratio forced to one
// - rc postscaler divides by 1 to 64 or 256, reset divide by 1
// - pll output divider 2, 4 or 8, code 10 reserved, reset 01
// - pll input prescaler divides by field plus two
// - pll feedback multiplier is field plus two, reset gives 50
// - rc trim is signed, zero nominal, 011111 highest, 100000 lowest
// - unimplemented bits ignore writes and read as zero
// - request to the active source is cleared and aborted
// - wait ten new source cycles once stable and locked, then switch
// - on completion copy new source into current source, clear request
// - with switching disabled request stays zero, current follows startup
//
// Our own choices: strobed register access and the address map.
`timescale 1ns/1ns
`default_nettype none
module clk_ctrl
   import clk_ctrl_pkg::*;
(
   input  wire logic                   i_clk_sys,
   input  wire logic                   i_arst_n,
   input  wire clk_ctrl_pkg::reg_req_t i_req,
   output var  logic [15:0]            o_rdata,
   input  wire logic [2:0]             i_startup_source,
   input  wire logic                   i_lock_permit_config,
   input  wire logic                   i_switch_permit_config_n,
   input  wire logic                   i_pll_locked,
   input  wire logic                   i_new_source_ready,
   input  wire logic                   i_new_source_tick,
   input  wire logic                   i_clock_fail_event,
   input  wire logic                   i_interrupt,
   output var  logic [2:0]             o_active_source,
   output var  logic [2:0]             o_target_source,
   output var  logic                   o_target_enable,
   output var  logic                   o_secondary_osc_enable,
   output var  clk_ctrl_pkg::clk_cfg_t o_cfg,
   output var  logic                   o_pll_reset
);
   import clk_ctrl_pkg::*;

   typedef enum logic [1:0] {
      SW_IDLE   = 2'b00,
      SW_START  = 2'b01,
      SW_WAIT   = 2'b10,
      SW_SETTLE = 2'b11
   } sw_state_t;

   sw_state_t  state_reg, state_next;
   logic [2:0] current_source_select_reg;
   logic [2:0] new_source_select_reg;
   logic       config_freeze_bit_reg;
   logic       pll_lock_reg;
   logic       clock_fail_flag_reg;
   logic       secondary_osc_enable_reg;
   logic       switch_request_reg;
   logic       recover_on_interrupt_reg;
   logic [2:0] reduction_reg;
   logic       clock_reduction_enable_reg;
   logic [2:0] internal_rc_postscaler_reg;
   logic [1:0] pll_output_divider_reg;
   logic [4:0] pll_input_prescaler_reg;
   logic [8:0] pll_feedback_multiplier_reg;
   logic [5:0] rc_trim_reg;
   logic [1:0] unlock_reg;
   logic [3:0] settle_reg;
   logic       strap_done_reg;
   logic [15:0] rdata_reg;

   // write decode
   wire switching_on = ~i_switch_permit_config_n;
   wire frozen       = config_freeze_bit_reg & i_lock_permit_config;
   wire unlocked     = (unlock_reg == 2'h2);
   wire wr_osc       = i_req.wr & (i_req.addr == OFS_OSC_CONTROL) & unlocked;
   wire wr_div       = i_req.wr & (i_req.addr == OFS_CLOCK_DIVISOR);
   wire wr_fbd       = i_req.wr & (i_req.addr == OFS_PLL_FEEDBACK) & ~frozen;
   wire wr_tun       = i_req.wr & (i_req.addr == OFS_RC_TUNING);
   wire wr_unl       = i_req.wr & (i_req.addr == OFS_UNLOCK);
   wire wr_osc_sel   = wr_osc & ~frozen;
   wire wr_div_pll   = wr_div & ~frozen;
   wire [15:0] wd    = i_req.wdata;
   wire sw_start     = (state_reg == SW_START);
   wire redundant    = (new_source_select_reg == current_source_select_reg);
   wire uses_pll     = (new_source_select_reg == SRC_RC_PLL) |
                       (new_source_select_reg == SRC_PRI_PLL);
   wire src_stable   = i_new_source_ready & (~uses_pll | i_pll_locked);
   wire sw_done      = (state_reg == SW_SETTLE) & i_new_source_tick &
                       (settle_reg == SETTLE_CYCLES - 4'h1) & src_stable;
   wire sw_abort     = (state_reg == SW_IDLE) & switch_request_reg & redundant;

   // switch sequencer
   always_comb
   begin
      state_next = state_reg;
      unique case (state_reg)
         SW_IDLE:
            if (switch_request_reg & ~redundant & switching_on)
               state_next = SW_START;
         SW_START:
            state_next = SW_WAIT;
         SW_WAIT:
            if (src_stable)
               state_next = SW_SETTLE;
         SW_SETTLE:
            if (~src_stable)
               state_next = SW_WAIT;
            else if (sw_done)
               state_next = SW_IDLE;
      endcase
   end

   // power-on reset only; no other reset reaches these flops
   always_ff @(posedge i_clk_sys or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         state_reg  <= SW_IDLE;
         settle_reg <= 4'h0;
         unlock_reg <= 2'h0;
      end
      else
      begin
         state_reg <= state_next;
         if (state_reg != SW_SETTLE || ~src_stable)
            settle_reg <= 4'h0;
         else if (i_new_source_tick)
            settle_reg <= settle_reg + 4'h1;
         if (wr_unl && wd == UNLOCK_KEY1)
            unlock_reg <= 2'h1;
         else if (wr_unl && wd == UNLOCK_KEY2 && unlock_reg == 2'h1)
            unlock_reg <= 2'h2;
         else if (i_req.wr)
            unlock_reg <= 2'h0;
      end
   end

   // oscillator control next values
   wire       strap_load   = ~strap_done_reg;
   wire       new_write_ok = wr_osc_sel & (state_reg == SW_IDLE) & ~switch_request_reg;
   wire [2:0] current_source_select_next =
                 strap_load    ? i_startup_source :
                 ~switching_on ? i_startup_source :
                 sw_done       ? new_source_select_reg :
                                 current_source_select_reg;
   wire [2:0] new_source_select_next =
                 strap_load   ? i_startup_source :
                 new_write_ok ? wd[NEW_LSB +: 3] :
                                new_source_select_reg;
   // freeze bit is write-once until power-on reset
   wire       freeze_write_ok        = wr_osc & ~config_freeze_bit_reg;
   wire       config_freeze_bit_next = freeze_write_ok ? wd[FREEZE_BIT] : config_freeze_bit_reg;
   wire       secondary_osc_enable_next = wr_osc ? wd[SEC_BIT]
                                                 : secondary_osc_enable_reg;
   // lock status follows the pll, cleared at switch start
   wire       pll_lock_next = i_pll_locked & ~sw_start;
   // monitor event wins over a clear in the same cycle
   wire       fail_clear           = sw_start | (wr_osc & ~wd[FAIL_BIT]);
   wire       clock_fail_flag_next = i_clock_fail_event |
                                     (clock_fail_flag_reg & ~fail_clear);
   wire       req_clear           = ~switching_on | sw_done | sw_abort;
   wire       req_set             = wr_osc_sel & wd[REQ_BIT];
   wire       switch_request_next = ~req_clear & (req_set | switch_request_reg);

   // divisor, feedback and trim next values
   wire       recover_on_interrupt_next = wr_div ? wd[ROI_BIT] : recover_on_interrupt_reg;
   wire [2:0] reduction_next = wr_div ? wd[RED_LSB +: 3] : reduction_reg;
   // interrupt recovery wins over a simultaneous write
   wire       irq_recover = i_interrupt & recover_on_interrupt_reg;
   wire       clock_reduction_enable_next = irq_recover ? 1'b0 :
                                            wr_div      ? wd[REDEN_BIT] :
                                                          clock_reduction_enable_reg;
   wire [2:0] internal_rc_postscaler_next = wr_div_pll ? wd[RCDIV_LSB +: 3]
                                                       : internal_rc_postscaler_reg;
   wire [1:0] pll_output_divider_next = wr_div_pll ? wd[POST_LSB +: 2]
                                                   : pll_output_divider_reg;
   wire [4:0] pll_input_prescaler_next = wr_div_pll ? wd[PRE_LSB +: 5]
                                                    : pll_input_prescaler_reg;
   wire [8:0] pll_feedback_multiplier_next = wr_fbd ? wd[8:0]
                                                    : pll_feedback_multiplier_reg;
   wire [5:0] rc_trim_next = wr_tun ? wd[5:0] : rc_trim_reg;

   // power-on reset only: one short block per register
   always_ff @(posedge i_clk_sys or negedge i_arst_n)
   begin
      if (!i_arst_n)
         strap_done_reg <= 1'b0;
      else
         strap_done_reg <= 1'b1;
   end

   always_ff @(posedge i_clk_sys or negedge i_arst_n)
   begin
      if (!i_arst_n)
         current_source_select_reg <= SRC_RC;
      else
         current_source_select_reg <= current_source_select_next;
   end

   always_ff @(posedge i_clk_sys or negedge i_arst_n)
   begin
      if (!i_arst_n)
         new_source_select_reg <= SRC_RC;
      else
         new_source_select_reg <= new_source_select_next;
   end

   always_ff @(posedge i_clk_sys or negedge i_arst_n)
   begin
      if (!i_arst_n)
         config_freeze_bit_reg <= 1'b0;
      else
         config_freeze_bit_reg <= config_freeze_bit_next;
   end

   always_ff @(posedge i_clk_sys or negedge i_arst_n)
   begin
      if (!i_arst_n)
         pll_lock_reg <= 1'b0;
      else
         pll_lock_reg <= pll_lock_next;
   end

   always_ff @(posedge i_clk_sys or negedge i_arst_n)
   begin
      if (!i_arst_n)
         clock_fail_flag_reg <= 1'b0;
      else
         clock_fail_flag_reg <= clock_fail_flag_next;
   end

   always_ff @(posedge i_clk_sys or negedge i_arst_n)
   begin
      if (!i_arst_n)
         secondary_osc_enable_reg <= 1'b0;
      else
         secondary_osc_enable_reg <= secondary_osc_enable_next;
   end

   always_ff @(posedge i_clk_sys or negedge i_arst_n)
   begin
      if (!i_arst_n)
         switch_request_reg <= 1'b0;
      else
         switch_request_reg <= switch_request_next;
   end

   always_ff @(posedge i_clk_sys or negedge i_arst_n)
   begin
      if (!i_arst_n)
         recover_on_interrupt_reg <= 1'b0;
      else
         recover_on_interrupt_reg <= recover_on_interrupt_next;
   end

   always_ff @(posedge i_clk_sys or negedge i_arst_n)
   begin
      if (!i_arst_n)
         reduction_reg <= RED_RESET;
      else
         reduction_reg <= reduction_next;
   end

   always_ff @(posedge i_clk_sys or negedge i_arst_n)
   begin
      if (!i_arst_n)
         clock_reduction_enable_reg <= 1'b0;
      else
         clock_reduction_enable_reg <= clock_reduction_enable_next;
   end

   always_ff @(posedge i_clk_sys or negedge i_arst_n)
   begin
      if (!i_arst_n)
         internal_rc_postscaler_reg <= RCDIV_RESET;
      else
         internal_rc_postscaler_reg <= internal_rc_postscaler_next;
   end

   always_ff @(posedge i_clk_sys or negedge i_arst_n)
   begin
      if (!i_arst_n)
         pll_output_divider_reg <= POST_RESET;
      else
         pll_output_divider_reg <= pll_output_divider_next;
   end

   always_ff @(posedge i_clk_sys or negedge i_arst_n)
   begin
      if (!i_arst_n)
         pll_input_prescaler_reg <= PRE_RESET;
      else
         pll_input_prescaler_reg <= pll_input_prescaler_next;
   end

   always_ff @(posedge i_clk_sys or negedge i_arst_n)
   begin
      if (!i_arst_n)
         pll_feedback_multiplier_reg <= MULT_RESET;
      else
         pll_feedback_multiplier_reg <= pll_feedback_multiplier_next;
   end

   always_ff @(posedge i_clk_sys or negedge i_arst_n)
   begin
      if (!i_arst_n)
         rc_trim_reg <= TRIM_RESET;
      else
         rc_trim_reg <= rc_trim_next;
   end

   // read mux, unimplemented bits zero
   wire [15:0] rd_osc = {1'b0,
                         current_source_select_reg,
                         1'b0,
                         new_source_select_reg,
                         config_freeze_bit_reg,
                         1'b0,
                         pll_lock_reg,
                         1'b0,
                         clock_fail_flag_reg,
                         1'b0,
                         secondary_osc_enable_reg,
                         switch_request_reg};
   wire [15:0] rd_div = {recover_on_interrupt_reg,
                         reduction_reg,
                         clock_reduction_enable_reg,
                         internal_rc_postscaler_reg,
                         pll_output_divider_reg,
                         1'b0,
                         pll_input_prescaler_reg};
   wire [15:0] rd_fbd = {7'h00, pll_feedback_multiplier_reg};
   wire [15:0] rd_tun = {10'h000, rc_trim_reg};
   wire [15:0] rd_sel = (i_req.addr == OFS_OSC_CONTROL)   ? rd_osc :
                        (i_req.addr == OFS_CLOCK_DIVISOR) ? rd_div :
                        (i_req.addr == OFS_PLL_FEEDBACK)  ? rd_fbd :
                        (i_req.addr == OFS_RC_TUNING)     ? rd_tun : 16'h0000;

   always_ff @(posedge i_clk_sys or negedge i_arst_n)
   begin
      if (!i_arst_n)
         rdata_reg <= 16'h0000;
      else
         rdata_reg <= i_req.rd ? rd_sel : 16'h0000;
   end

   assign o_rdata                = rdata_reg;
   assign o_active_source        = current_source_select_reg;
   assign o_target_source        = new_source_select_reg;
   assign o_target_enable        = (state_reg != SW_IDLE);
   assign o_pll_reset            = sw_start;
   assign o_secondary_osc_enable = secondary_osc_enable_reg;
   // effective reduction: forced to 1:1 while disabled
   assign o_cfg.reduction_ratio         = clock_reduction_enable_reg ? reduction_reg
                                                                     : 3'h0;
   assign o_cfg.reduction_active        = clock_reduction_enable_reg;
   assign o_cfg.rc_postscaler           = internal_rc_postscaler_reg;
   assign o_cfg.pll_output_divider      = pll_output_divider_reg;
   assign o_cfg.pll_input_prescaler     = pll_input_prescaler_reg;
   assign o_cfg.pll_feedback_multiplier = pll_feedback_multiplier_reg;
   assign o_cfg.rc_trim                 = rc_trim_reg;
endmodule
`default_nettype wire

// ### clk_ctrl_asserts.sv
// assertion checker bound to the clock control block
`timescale 1ns/1ns
`default_nettype none
module clk_ctrl_asserts
   import clk_ctrl_pkg::*;
(
   input wire logic                   i_clk_sys,
   input wire logic                   i_arst_n,
   input wire clk_ctrl_pkg::reg_req_t i_req,
   input wire logic [15:0]            o_rdata,
   input wire logic                   i_switch_permit_config_n,
   input wire logic                   i_pll_locked,
   input wire logic                   i_new_source_ready,
   input wire logic                   i_new_source_tick,
   input wire logic                   i_clock_fail_event,
   input wire logic [2:0]             o_active_source,
   input wire logic [2:0]             o_target_source,
   input wire logic                   o_target_enable,
   input wire clk_ctrl_pkg::clk_cfg_t o_cfg,
   input wire logic                   o_pll_reset
);
   logic [3:0]  tick_cnt_reg;
   logic [2:0]  rd_addr_reg;
   wire  [15:0] unimp_mask;
   default clocking dc @(posedge i_clk_sys); endclocking
   default disable iff (!i_arst_n);
   // ticks of the new source seen while it is ready during a switch
   always_ff @(posedge i_clk_sys or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         tick_cnt_reg <= 4'h0;
         rd_addr_reg  <= 3'h0;
      end
      else
      begin
         rd_addr_reg  <= i_req.addr;
         tick_cnt_reg <= (o_target_enable && i_new_source_ready) ?
                         tick_cnt_reg + {3'h0, i_new_source_tick} : 4'h0;
      end
   end
   assign unimp_mask = (rd_addr_reg == OFS_OSC_CONTROL)   ? 16'h8854 :
                       (rd_addr_reg == OFS_CLOCK_DIVISOR) ? 16'h0020 :
                       (rd_addr_reg == OFS_PLL_FEEDBACK)  ? 16'hFE00 :
                       (rd_addr_reg == OFS_RC_TUNING)     ? 16'hFFC0 : 16'hFFFF;
   a_unimp_zero: assert property ($past(i_req.rd) |-> (o_rdata & unimp_mask) == 16'h0000)
      else $error("unimplemented bits read nonzero");
   a_cur_src_read: assert property (i_req.rd && i_req.addr == OFS_OSC_CONTROL
      |=> o_rdata[14:12] == $past(o_active_source)) else $error("current source misread");
   a_lock_out_read: assert property (i_req.rd && i_req.addr == OFS_OSC_CONTROL
      && !$past(i_pll_locked) |=> !o_rdata[LOCK_BIT]) else $error("lock read while unlocked");
   a_fail_flag_set: assert property (i_clock_fail_event && !o_target_enable ##1 !i_req.wr ##1
      (i_req.rd && i_req.addr == OFS_OSC_CONTROL && !o_target_enable) |=> o_rdata[FAIL_BIT])
      else $error("clock fail flag not set");
   a_ratio_forced: assert property (!o_cfg.reduction_active |-> o_cfg.reduction_ratio == 3'h0)
      else $error("reduction ratio not forced to one");
   a_settle_count: assert property ($fell(o_target_enable) |->
      $past(tick_cnt_reg) == 4'h9 && $past(i_new_source_tick)) else $error("settle count wrong");
   a_switch_copies: assert property ($fell(o_target_enable) |-> o_active_source == o_target_source)
      else $error("new source not copied on completion");
   a_start_pulse: assert property (o_pll_reset |-> o_target_enable ##1 !o_pll_reset)
      else $error("pll reset pulse outside switch start");
   a_no_redundant: assert property ($rose(o_target_enable) |-> o_target_source != o_active_source)
      else $error("redundant switch started");
   a_switch_blocked: assert property (i_switch_permit_config_n && !o_target_enable
      |=> !o_target_enable) else $error("switch started while disabled");
endmodule
bind clk_ctrl clk_ctrl_asserts u_chk (.*);
`default_nettype wire

// ### clk_ctrl_tb.sv
// self-checking testbench for the clock control block
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import clk_ctrl_pkg::*;
   logic        i_clk_sys, i_arst_n, i_lock_permit_config, i_switch_permit_config_n;
   logic        i_pll_locked, i_new_source_ready, i_new_source_tick, i_clock_fail_event;
   logic        i_interrupt, o_target_enable, o_secondary_osc_enable, o_pll_reset;
   logic [2:0]  i_startup_source, o_active_source, o_target_source;
   logic [15:0] o_rdata, d, e;
   reg_req_t    i_req;
   clk_cfg_t    o_cfg;
   int          errors, checks_done, n;
   clk_ctrl DUT (.*);
   initial
   begin
      i_clk_sys = 1'b0;
      forever #4 i_clk_sys = ~i_clk_sys;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         errors++;
         $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask
   task automatic finish_test();
      $display("errors %0d checks %0d", errors, checks_done);
      if (errors == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic wr(input logic [2:0] a, input logic [15:0] v);
      @(posedge i_clk_sys);
      i_req.addr <= a;
      i_req.wdata <= v;
      i_req.wr <= 1'b1;
      @(posedge i_clk_sys);
      i_req.wr <= 1'b0;
   endtask
   task automatic rchk(input logic [2:0] a, input logic [15:0] m, input logic [15:0] x);
      @(posedge i_clk_sys);
      i_req.addr <= a;
      i_req.rd <= 1'b1;
      @(posedge i_clk_sys);
      i_req.rd <= 1'b0;
      #1 d = o_rdata;
      chk({16'h0000, d & m}, {16'h0000, x});
   endtask
   task automatic osc_wr(input logic [15:0] v);
      wr(OFS_UNLOCK, UNLOCK_KEY1);
      wr(OFS_UNLOCK, UNLOCK_KEY2);
      wr(OFS_OSC_CONTROL, v);
   endtask
   task automatic irq_pulse();
      @(posedge i_clk_sys);
      i_interrupt <= 1'b1;
      @(posedge i_clk_sys);
      i_interrupt <= 1'b0;
   endtask
   task automatic por();
      i_arst_n <= 1'b0;
      repeat (3) @(posedge i_clk_sys);
      i_arst_n <= 1'b1;
      repeat (2) @(posedge i_clk_sys);
      rchk(OFS_OSC_CONTROL, 16'hFFFF, 16'h2200);
      rchk(OFS_CLOCK_DIVISOR, 16'hFFFF, 16'h3040);
      rchk(OFS_PLL_FEEDBACK, 16'hFFFF, 16'h0030);
      rchk(OFS_RC_TUNING, 16'hFFFF, 16'h0000);
      rchk(OFS_UNLOCK, 16'hFFFF, 16'h0000);
      rchk(3'h5, 16'hFFFF, 16'h0000);
      chk({3'h0, o_cfg}, {10'h000, 2'h1, 5'h00, 9'h030, 6'h00});
   endtask
   initial
   begin
      errors = 0;
      checks_done = 0;
      i_arst_n = 1'b0;
      i_req = '0;
      i_startup_source = SRC_PRI;
      {i_lock_permit_config, i_switch_permit_config_n, i_pll_locked} = 3'h0;
      {i_new_source_ready, i_new_source_tick, i_clock_fail_event, i_interrupt} = 4'h0;
      por();
      i_pll_locked <= 1'b1;
      i_new_source_ready <= 1'b1;
      for (int k = 0; k < 8; k++)
      begin
         e = {1'b0, 3'(k), 1'b1, 3'(k), (k[0] ? 2'h3 : 2'h0), 1'b0, 5'(k * 4 + 3)};
         wr(OFS_CLOCK_DIVISOR, e);
         #1 chk({18'h0, o_cfg[28:15]}, {18'h0, e[14:6], e[4:0]});
         rchk(OFS_CLOCK_DIVISOR, 16'hFFFF, e);
      end
      wr(OFS_CLOCK_DIVISOR, 16'hF7FF);
      #1 chk({29'h0, o_cfg.reduction_ratio}, 32'h0);
      rchk(OFS_CLOCK_DIVISOR, 16'hFFFF, 16'hF7DF);
      wr(OFS_CLOCK_DIVISOR, 16'hB8C5);
      irq_pulse();
      #1 chk({31'h0, o_cfg.reduction_active}, 32'h0);
      rchk(OFS_CLOCK_DIVISOR, 16'hFFFF, 16'hB0C5);
      wr(OFS_CLOCK_DIVISOR, 16'h38C5);
      irq_pulse();
      rchk(OFS_CLOCK_DIVISOR, 16'hFFFF, 16'h38C5);
      wr(OFS_PLL_FEEDBACK, 16'hFFFF);
      rchk(OFS_PLL_FEEDBACK, 16'hFFFF, 16'h01FF);
      wr(OFS_RC_TUNING, 16'hFFE0);
      rchk(OFS_RC_TUNING, 16'hFFFF, 16'h0020);
      chk({17'h0, o_cfg.pll_feedback_multiplier, o_cfg.rc_trim}, {17'h0, 9'h1FF, 6'h20});
      wr(OFS_OSC_CONTROL, 16'h0002);
      wr(OFS_UNLOCK, UNLOCK_KEY1);
      wr(OFS_UNLOCK, UNLOCK_KEY2);
      wr(OFS_RC_TUNING, 16'h0000);
      wr(OFS_OSC_CONTROL, 16'h0002);
      rchk(OFS_OSC_CONTROL, 16'h0002, 16'h0000);
      osc_wr(16'h0202);
      rchk(OFS_OSC_CONTROL, 16'h0702, 16'h0202);
      chk({31'h0, o_secondary_osc_enable}, 32'h1);
      @(posedge i_clk_sys);
      i_clock_fail_event <= 1'b1;
      @(posedge i_clk_sys);
      i_clock_fail_event <= 1'b0;
      rchk(OFS_OSC_CONTROL, 16'h0008, 16'h0008);
      osc_wr(16'h020A);
      rchk(OFS_OSC_CONTROL, 16'h0008, 16'h0008);
      osc_wr(16'h0202);
      rchk(OFS_OSC_CONTROL, 16'h0008, 16'h0000);
      osc_wr(16'h020A);
      rchk(OFS_OSC_CONTROL, 16'h0008, 16'h0000);
      osc_wr(16'h0002);
      @(posedge i_clk_sys);
      i_clock_fail_event <= 1'b1;
      @(posedge i_clk_sys);
      i_clock_fail_event <= 1'b0;
      osc_wr(16'h000B);
      #1 n = 0;
      while (o_target_enable !== 1'b1 && n < 50)
      begin
         @(posedge i_clk_sys);
         #1 n++;
      end
      chk({31'h0, o_target_enable}, 32'h1);
      if (o_target_enable !== 1'b1)
         finish_test();
      repeat (3) @(posedge i_clk_sys);
      n = 0;
      while (o_target_enable === 1'b1 && n < 20)
      begin
         @(posedge i_clk_sys);
         i_new_source_tick <= 1'b1;
         @(posedge i_clk_sys);
         i_new_source_tick <= 1'b0;
         #1 n++;
      end
      chk(n, 32'h0000000A);
      if (o_target_enable === 1'b1)
         finish_test();
      rchk(OFS_OSC_CONTROL, 16'hFFFF, 16'h0022);
      osc_wr(16'h0003);
      repeat (3) @(posedge i_clk_sys);
      #1 chk({31'h0, o_target_enable}, 32'h0);
      rchk(OFS_OSC_CONTROL, 16'h0001, 16'h0000);
      i_switch_permit_config_n <= 1'b1;
      osc_wr(16'h0002);
      osc_wr(16'h0003);
      repeat (3) @(posedge i_clk_sys);
      #1 chk({31'h0, o_target_enable}, 32'h0);
      rchk(OFS_OSC_CONTROL, 16'h0001, 16'h0000);
      chk({29'h0, o_active_source}, {29'h0, SRC_PRI});
      i_switch_permit_config_n <= 1'b0;
      i_lock_permit_config <= 1'b1;
      osc_wr(16'h0282);
      wr(OFS_CLOCK_DIVISOR, 16'h3800);
      rchk(OFS_CLOCK_DIVISOR, 16'h07FF, 16'h00C5);
      wr(OFS_PLL_FEEDBACK, 16'h0031);
      rchk(OFS_PLL_FEEDBACK, 16'hFFFF, 16'h01FF);
      osc_wr(16'h0582);
      rchk(OFS_OSC_CONTROL, 16'h0780, 16'h0280);
      i_lock_permit_config <= 1'b0;
      wr(OFS_PLL_FEEDBACK, 16'h0031);
      rchk(OFS_PLL_FEEDBACK, 16'hFFFF, 16'h0031);
      i_pll_locked <= 1'b0;
      por();
      finish_test();
   end
endmodule
`default_nettype wire
